// [dv/core_stream_model.sv]
// Behavioural core stream: one pulse per completed or skipped instruction.
// Assumes the bench calls issue from one thread only.
module core_stream_model (
    // Clock
    input  wire logic   clk,
    // Instruction stream
    output logic        execValid,
    output logic [15:0] execAddr,
    output logic        execDeferClass,
    output logic [7:0]  probeData
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Stream
    // ----------------------------------------
    initial
    begin
        execValid = 1'b0;
        execAddr = 16'h0;
        execDeferClass = 1'b0;
        probeData = 8'h0;
    end

    // Fields invert afterwards so a stale value can never match
    task automatic issue(input logic [15:0] a, input logic d, input logic [7:0] p);
        @(posedge clk);
        execValid <= 1'b1;
        execAddr <= a;
        execDeferClass <= d;
        probeData <= p;
        @(posedge clk);
        execValid <= 1'b0;
        execAddr <= ~a;
        execDeferClass <= ~d;
        probeData <= ~p;
    endtask
endmodule

// [dv/emulator_event_detector_test.sv]
// Self-checking bench for the event detector through APB and the core stream.
// Assumes the defines header is on the include path.
`include "event_detector_defines.vh"
module emulator_event_detector_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
    logic        execValid, execDeferClass, eventOut, breakOut, traceActive;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] execAddr;
    logic [7:0]  probeData;
    logic [3:0]  dataEventHit;
    int          n_mismatch;
    int          compares;

    emulator_event_detector dut (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .execValid(execValid), .execAddr(execAddr),
        .execDeferClass(execDeferClass), .probeData(probeData),
        .dataEventHit(dataEventHit), .eventOut(eventOut), .breakOut(breakOut),
        .traceActive(traceActive));
    core_stream_model core (
        .clk(clk), .execValid(execValid), .execAddr(execAddr),
        .execDeferClass(execDeferClass), .probeData(probeData));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic finish_test;
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Bounded wait: a slave that never answers ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            n_mismatch++;
            finish_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cond(input logic [2:0] i, input logic [31:0] am, input logic [15:0] pm);
        apb(1'b1, `OFS_CONDADDR, am);
        apb(1'b1, `OFS_CONDPROBE, {16'h0, pm});
        apb(1'b1, `OFS_CONDIDX, {23'h0, 1'b1, 5'h0, i});
    endtask

    task automatic run(input logic [15:0] a, input logic d, input logic [7:0] p,
                       input logic [1:0] e);
        core.issue(a, d, p);
        #1;
        chk({30'h0, eventOut, breakOut}, {30'h0, e});
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_match;
        apb(1'b0, `OFS_MODE, 32'h0);
        chk(rd, {26'h0, `MODE_RESET});
        apb(1'b0, 12'h01c, 32'h0);
        chk({err, rd[30:0]}, 32'h8000_0000);
        cond(3'h0, 32'h0000_1234, 16'hff00);
        cond(3'h1, 32'h000f_2000, 16'hff00);
        cond(3'h2, 32'hffff_0000, 16'h005a);
        apb(1'b1, `OFS_MULTICFG, 32'h7);
        run(16'h1234, 1'b0, 8'h00, 2'b11);
        run(16'h1235, 1'b0, 8'h00, 2'b00);
        run(16'h200c, 1'b0, 8'h00, 2'b11);
        run(16'h2010, 1'b0, 8'h00, 2'b00);
        run(16'h7777, 1'b0, 8'h5a, 2'b11);
        run(16'h7777, 1'b0, 8'h5b, 2'b00);
        apb(1'b1, `OFS_MULTICFG, 32'hf);
        run(16'h7777, 1'b0, 8'h00, 2'b11);
        $display("match test done");
    endtask

    task automatic t_defer;
        apb(1'b1, `OFS_MULTICFG, 32'h7);
        run(16'h1234, 1'b1, 8'h00, 2'b10);
        run(16'h3000, 1'b0, 8'h00, 2'b01);
        run(16'h1234, 1'b1, 8'h00, 2'b10);
        run(16'h3000, 1'b1, 8'h00, 2'b00);
        run(16'h3002, 1'b0, 8'h00, 2'b01);
        apb(1'b1, `OFS_MULTICFG, 32'h4);
        run(16'h2003, 1'b0, 8'h00, 2'b00);
        run(16'h1234, 1'b0, 8'h00, 2'b00);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk({29'h0, rd[`ST_STEP_LO +: `CNT_W]}, 32'h1);
        run(16'h3000, 1'b0, 8'h00, 2'b00);
        run(16'h2001, 1'b0, 8'h00, 2'b11);
        run(16'h2001, 1'b0, 8'h00, 2'b00);
        run(16'h1234, 1'b0, 8'h00, 2'b00);
        apb(1'b1, `OFS_MULTICFG, 32'h4);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk({29'h0, rd[`ST_STEP_LO +: `CNT_W]}, 32'h0);
        $display("order test done");
    endtask

    task automatic t_mode;
        apb(1'b1, `OFS_MULTICFG, 32'h7);
        apb(1'b1, `OFS_MODE, 32'h0);
        run(16'h1234, 1'b0, 8'h00, 2'b00);
        cond(3'h7, 32'h0000_4000, 16'hff00);
        apb(1'b1, `OFS_MODE, 32'h20);
        run(16'h1234, 1'b0, 8'h00, 2'b00);
        run(16'h4000, 1'b0, 8'h00, 2'b11);
        apb(1'b1, `OFS_MODE, 32'h01);
        dataEventHit <= 4'h1;
        run(16'h9999, 1'b0, 8'h00, 2'b11);
        @(posedge clk);
        dataEventHit <= 4'h2;
        run(16'h9999, 1'b0, 8'h00, 2'b00);
        @(posedge clk);
        dataEventHit <= 4'h0;
        apb(1'b1, `OFS_OUTUSE, 32'h3);
        apb(1'b1, `OFS_MODE, 32'h3f);
        apb(1'b0, `OFS_MODE, 32'h0);
        chk(rd, 32'h33);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk({31'h0, rd[`ST_REFUSED_BIT]}, 32'h1);
        apb(1'b1, `OFS_OUTUSE, 32'h0);
        apb(1'b1, `OFS_MODE, 32'h3f);
        apb(1'b0, `OFS_MODE, 32'h0);
        chk(rd, 32'h3f);
        apb(1'b1, `OFS_MODE, 32'h30);
        run(16'h1234, 1'b0, 8'h00, 2'b11);
        chk({31'h0, traceActive}, 32'h1);
        run(16'h5000, 1'b0, 8'h00, 2'b00);
        run(16'h4000, 1'b0, 8'h00, 2'b11);
        chk({31'h0, traceActive}, 32'h0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd, 32'h31);
        apb(1'b1, `OFS_STATUS, 32'h31);
        apb(1'b0, `OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        $display("mode test done");
    endtask

    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        dataEventHit = 4'h0;
        n_mismatch = 0;
        compares = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_match();
        t_defer();
        t_mode();
        finish_test();
    end
endmodule

// [dv/event_detector_chk.sv]
// Port-level assertions for the event detector.
// Assumes one clock domain and an active high asynchronous reset.
module event_detector_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Core stream and events
    input wire logic        execValid,
    input wire logic        execDeferClass,
    input wire logic        eventOut,
    input wire logic        breakOut,
    input wire logic        traceActive
);
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wait_state_a: assert property (psel && !penable ##1 psel && penable |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable && $past(penable))
        else $error("pready outside access phase");
    error_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
    event_cause_a: assert property (eventOut |-> $past(execValid))
        else $error("event without instruction");
    break_cause_a: assert property (breakOut |-> $past(execValid) && !$past(execDeferClass))
        else $error("break after deferred class instruction");
    trace_cause_a: assert property ($changed(traceActive) |-> $past(execValid))
        else $error("trace window moved without instruction");
    quiet_start_a: assert property ($fell(rst) |-> !eventOut && !breakOut && !traceActive)
        else $error("outputs active after reset");

    cover property (eventOut && breakOut);
    cover property (eventOut && !breakOut);
    cover property ($fell(traceActive));
endmodule

bind emulator_event_detector event_detector_chk chk (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .execValid(execValid),
    .execDeferClass(execDeferClass), .eventOut(eventOut), .breakOut(breakOut),
    .traceActive(traceActive)
);

// [src/cond_match.v]
// One masked comparison of an entry against the executed address and probe.
// Assumes entry layout from the defines header; mask bit 1 is don't-care.
`include "event_detector_defines.vh"

module cond_match (
    // Entry under test
    input  wire [`ENTRY_W-1:0]  entry,
    // Observed values
    input  wire [`ADDR_W-1:0]   execAddr,
    input  wire [`PROBE_W-1:0]  probeData,
    // Result
    output wire                 hit
);

    function masked_eq;
        input [`ADDR_W-1:0] want;
        input [`ADDR_W-1:0] mask;
        input [`ADDR_W-1:0] seen;
        begin
            masked_eq = &(~(want ^ seen) | mask);
        end
    endfunction

    assign hit = masked_eq(entry[`FLD_ADDR_LO +: `ADDR_W],
                           entry[`FLD_AMASK_LO +: `ADDR_W], execAddr) &&  // R13 R17
                 masked_eq({8'h00, entry[`FLD_PROBE_LO +: `PROBE_W]},
                           {8'hff, entry[`FLD_PMASK_LO +: `PROBE_W]},
                           {8'h00, probeData});                          // R14 R17

endmodule

// [src/cond_store.v]
// Condition entry storage: seven multi entries plus one single entry.
// Assumes one writer port driven from the register slave.
`include "event_detector_defines.vh"

module cond_store (
    // Clock and reset
    input  wire                              clk,
    input  wire                              rst,
    // Write port
    input  wire                              wrEn,
    input  wire [`IDX_W-1:0]                 wrIdx,
    input  wire [`ENTRY_W-1:0]               wrData,
    // All entries, registered
    output wire [`ENTRIES*`ENTRY_W-1:0]      entries
);

    reg [`ENTRY_W-1:0] mem [0:`ENTRIES-1];
    integer i;

    genvar g;
    generate
        for (g = 0; g < `ENTRIES; g = g + 1)
        begin : flat
            assign entries[g*`ENTRY_W +: `ENTRY_W] = mem[g];
        end
    endgenerate

    // Reset leaves every entry fully masked, so it matches any instruction until written
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            for (i = 0; i < `ENTRIES; i = i + 1)
                mem[i] <= {`ENTRY_W{1'b1}};
        end
        else if (wrEn)
        begin
            mem[wrIdx] <= wrData;
        end
    end

endmodule

// [src/emulator_event_detector.v]
// Event and break detector of the emulator, with its APB register slave.
// Assumes the core reports each completed or skipped instruction for one cycle
// on execValid, and data comparators report hits in that same cycle.
//
// Contract
// R01 - Mode selection holds up to six registers: four data, two program.
// R02 - Selection off raises no event and leaves execution undisturbed; a break already pending still fires on the next non-deferred instruction.
// R03 - After reset only the multi program register is selected.
// R04 - Only selected registers fire; unselected ones keep their contents.
// R05 - Data registers three and four refused while assigned to output use.
// R06 - Program condition matches executed address and probe value, triggers break.
// R07 - Hit on flag set, clear or bank select breaks after next instruction.
// R08 - Chained such instructions defer break until another type completes.
// R09 - Condition on a skipped instruction still fires.
// R10 - Multi register holds four sequential or seven parallel conditions.
// R11 - Sequential mode signals only after conditions met in order.
// R12 - Parallel mode signals on any one stored condition.
// R13 - Address condition is sixteen bits with per-bit don't-care mask.
// R14 - Probe condition is eight bits with per-bit mask.
// R15 - Single program register holds exactly one condition.
// R16 - Multi and single registers give section trace start and end.
// R17 - Masked bits compare equal; unmasked bits must match exactly.
//
// Local design decisions: the placing of the registers and the APB register port.
`include "event_detector_defines.vh"

module emulator_event_detector (
    // Clock and reset
    input  wire                clk,
    input  wire                rst,
    // APB slave
    input  wire                psel,
    input  wire                penable,
    input  wire                pwrite,
    input  wire [11:0]         paddr,
    input  wire [31:0]         pwdata,
    output reg  [31:0]         prdata,
    output reg                 pready,
    output reg                 pslverr,
    // Core instruction stream
    input  wire                execValid,
    input  wire [15:0]         execAddr,
    input  wire                execDeferClass,
    input  wire [7:0]          probeData,
    // Data comparator hits
    input  wire [3:0]          dataEventHit,
    // Event outputs
    output reg                 eventOut,
    output reg                 breakOut,
    output reg                 traceActive
);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    reg  [`SEL_W-1:0]       eventModeSelect;
    reg  [1:0]              outUse;
    reg                     parallelMode;
    reg  [`CNT_W-1:0]       condCount;
    reg  [`IDX_W-1:0]       condIdx;
    reg  [31:0]             stageAddr;
    reg  [15:0]             stageProbe;
    reg  [`SEL_W-1:0]       sourceSticky;
    reg                     refused;
    reg  [`CNT_W-1:0]       seqStep;
    reg                     breakPending;

    wire                    access;
    wire                    wrAcc;
    wire                    commit;
    wire [`ENTRIES*`ENTRY_W-1:0] entries;
    wire [`ENTRIES-1:0]     entryHit;
    wire [`SEL_W-1:0]       blockMask;
    wire [`SEL_W-1:0]       activeSel;
    wire [`CNT_W-1:0]       limit;
    wire [`CNT_W-1:0]       usedCount;
    wire                    seqHit;
    wire                    multiFire;
    wire                    singleHit;
    wire [`SEL_W-1:0]       rawHit;
    wire [`SEL_W-1:0]       hitVec;
    wire                    anyHit;
    wire                    breakNow;
    reg  [`ENTRIES-1:0]     parMask;
    reg                     addrOk;
    reg  [31:0]             next_prdata;
    integer                 k;

    // ----------------------------------------
    // Functions
    // ----------------------------------------
    // Output-use bits land on the selection bits of data three and four
    function [`SEL_W-1:0] outuse_mask;
        input [1:0] outBits;
        begin
            outuse_mask = `SEL_ZERO;
            outuse_mask[`SEL_DATA3] = outBits[0];
            outuse_mask[`SEL_DATA4] = outBits[1];
        end
    endfunction

    function wr_to;
        input        acc;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            wr_to = acc && (addr == ofs);
        end
    endfunction

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // One wait state so read data can come from a flip-flop
    assign access = psel && penable;
    assign wrAcc  = access && pready && pwrite && !pslverr;
    assign commit = wr_to(wrAcc, paddr, `OFS_CONDIDX) && pwdata[`COMMIT_BIT];

    always @*
    begin
        addrOk      = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            `OFS_MODE:      next_prdata[`SEL_W-1:0] = eventModeSelect;
            `OFS_OUTUSE:    next_prdata[1:0] = outUse;
            `OFS_MULTICFG:
            begin
                next_prdata[`CFG_PAR_BIT] = parallelMode;
                next_prdata[`CFG_CNT_LO +: `CNT_W] = condCount;
            end
            `OFS_CONDIDX:   next_prdata[`IDX_W-1:0] = condIdx;
            `OFS_CONDADDR:  next_prdata = stageAddr;
            `OFS_CONDPROBE: next_prdata[15:0] = stageProbe;
            `OFS_STATUS:
            begin
                next_prdata[`ST_SRC_LO +: `SEL_W] = sourceSticky;
                next_prdata[`ST_STEP_LO +: `CNT_W] = seqStep;
                next_prdata[`ST_REFUSED_BIT] = refused;
                next_prdata[`ST_TRACE_BIT] = traceActive;
                next_prdata[`ST_PEND_BIT] = breakPending;
            end
            default:        addrOk = 1'b0;
        endcase
    end

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= access && !pready;
            pslverr <= access && !pready && !addrOk;
            if (access && !pready)
                prdata <= next_prdata;
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    // Output-use assignment blocks data registers three and four
    assign blockMask = outuse_mask(outUse);

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            eventModeSelect <= `MODE_RESET;                            // R03
            outUse          <= 2'b00;
            parallelMode    <= 1'b0;
            condCount       <= `CNT_RESET;
            condIdx         <= `STEP_ZERO;
            stageAddr       <= `STAGE_ADDR_RST;
            stageProbe      <= `STAGE_PROBE_RST;
            refused         <= 1'b0;
        end
        else if (wrAcc)
        begin
            case (paddr)
                `OFS_MODE:
                begin
                    // Zero selects nothing, the off setting
                    eventModeSelect <= pwdata[`SEL_W-1:0] & ~blockMask; // R01 R02 R05
                    refused <= |(pwdata[`SEL_W-1:0] & blockMask);       // R05
                end
                `OFS_OUTUSE:
                begin
                    outUse <= pwdata[1:0];
                    eventModeSelect <= eventModeSelect & ~outuse_mask(pwdata[1:0]); // R05
                end
                `OFS_MULTICFG:
                begin
                    parallelMode <= pwdata[`CFG_PAR_BIT];
                    condCount    <= pwdata[`CFG_CNT_LO +: `CNT_W];
                end
                `OFS_CONDIDX:   condIdx <= pwdata[`IDX_W-1:0];
                `OFS_CONDADDR:  stageAddr <= pwdata;
                `OFS_CONDPROBE: stageProbe <= pwdata[15:0];
                default:        condIdx <= condIdx;
            endcase
        end
    end

    // ----------------------------------------
    // Condition storage and comparison
    // ----------------------------------------
    // Entry seven is the single register; zero to six form the multi one
    cond_store u_store (
        .clk     (clk),
        .rst     (rst),
        .wrEn    (commit),
        .wrIdx   (pwdata[`IDX_W-1:0]),
        .wrData  ({stageProbe, stageAddr}),
        .entries (entries)
    );

    genvar g;
    generate
        for (g = 0; g < `ENTRIES; g = g + 1)
        begin : cmp
            cond_match u_match (
                .entry     (entries[g*`ENTRY_W +: `ENTRY_W]),
                .execAddr  (execAddr),
                .probeData (probeData),
                .hit       (entryHit[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Multi register, sequential or parallel
    // ----------------------------------------
    // Counts beyond the mode limit are clipped rather than rejected
    assign limit     = parallelMode ? `PAR_MAX : `SEQ_MAX;                 // R10
    assign usedCount = (condCount > limit) ? limit :
                       ((condCount == `STEP_ZERO) ? `STEP_ONE : condCount);
    assign seqHit    = entryHit[seqStep];

    always @*
    begin
        for (k = 0; k < `ENTRIES; k = k + 1)
            parMask[k] = (k < usedCount);
    end

    assign multiFire = execValid && (parallelMode ?
                       |(entryHit & parMask) :                              // R12
                       (seqHit && (seqStep == usedCount - `STEP_ONE)));     // R11
    assign singleHit = execValid && entryHit[`SINGLE_IDX];                 // R15 R06

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            seqStep <= `STEP_ZERO;
        // A new count restarts the order, so no stale step survives it
        else if (wr_to(wrAcc, paddr, `OFS_MULTICFG))
            seqStep <= `STEP_ZERO;
        else if (parallelMode || !eventModeSelect[`SEL_PMULTI])
            seqStep <= `STEP_ZERO;
        else if (execValid && seqHit)
            seqStep <= multiFire ? `STEP_ZERO : seqStep + `STEP_ONE;       // R11
    end

    // ----------------------------------------
    // Event gating and break deferral
    // ----------------------------------------
    // execValid covers skipped instructions too, so they still fire
    assign activeSel = eventModeSelect & ~blockMask;                       // R05
    assign rawHit    = {singleHit, multiFire,
                        dataEventHit & {4{execValid}}};                     // R09
    assign hitVec    = rawHit & activeSel;                                  // R04 R02
    assign anyHit    = |hitVec;
    assign breakNow  = execValid && !execDeferClass &&
                       (breakPending || anyHit);                            // R08

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            eventOut     <= 1'b0;
            breakOut     <= 1'b0;
            breakPending <= 1'b0;
            traceActive  <= 1'b0;
            sourceSticky <= `SEL_ZERO;
        end
        else
        begin
            eventOut <= anyHit;                                            // R06
            breakOut <= breakNow;                                          // R07
            if (anyHit && execDeferClass)
                breakPending <= 1'b1;                                      // R07 R08
            else if (breakNow)
                breakPending <= 1'b0;
            // Single hit ends the window; a start in the same cycle wins
            if (hitVec[`SEL_PMULTI])
                traceActive <= 1'b1;                                       // R16
            else if (hitVec[`SEL_PSINGLE])
                traceActive <= 1'b0;                                       // R16
            // Write one to clear; a new hit in that cycle stays set
            sourceSticky <= (sourceSticky &
                             ~(wr_to(wrAcc, paddr, `OFS_STATUS) ?
                               pwdata[`SEL_W-1:0] : `SEL_ZERO)) | hitVec;
        end
    end

endmodule

// [src/event_detector_defines.vh]
// Constants for the emulator event detector: register map, fields, resets.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef EVENT_DETECTOR_DEFINES_VH
`define EVENT_DETECTOR_DEFINES_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_MODE        12'h000
`define OFS_OUTUSE      12'h004
`define OFS_MULTICFG    12'h008
`define OFS_CONDIDX     12'h00c
`define OFS_CONDADDR    12'h010
`define OFS_CONDPROBE   12'h014
`define OFS_STATUS      12'h018

// ----------------------------------------
// Selection bits of event_mode_select
// ----------------------------------------
`define SEL_W           6
`define SEL_DATA3       2
`define SEL_DATA4       3
`define SEL_PMULTI      4
`define SEL_PSINGLE     5
`define MODE_RESET      6'h10
`define SEL_ZERO        6'h00

// ----------------------------------------
// Condition storage
// ----------------------------------------
`define ENTRIES         8
`define IDX_W           3
`define SINGLE_IDX      3'h7
`define ENTRY_W         48
`define ADDR_W          16
`define PROBE_W         8
`define FLD_ADDR_LO     0
`define FLD_AMASK_LO    16
`define FLD_PROBE_LO    32
`define FLD_PMASK_LO    40
`define COMMIT_BIT      8
`define STAGE_ADDR_RST  32'hffff_0000
`define STAGE_PROBE_RST 16'hff00

// ----------------------------------------
// Multi register configuration
// ----------------------------------------
`define CFG_PAR_BIT     0
`define CFG_CNT_LO      1
`define CNT_W           3
`define SEQ_MAX         3'h4
`define PAR_MAX         3'h7
`define CNT_RESET       3'h1
`define STEP_ZERO       3'h0
`define STEP_ONE        3'h1

// ----------------------------------------
// Status fields
// ----------------------------------------
`define ST_SRC_LO       0
`define ST_STEP_LO      8
`define ST_REFUSED_BIT  12
`define ST_TRACE_BIT    13
`define ST_PEND_BIT     14

`endif
